// File: core/sccs_pkg.sv
// Summary of operation
// RULE_01: Any reset boots on the internal oscillator.
// RULE_02: Internal oscillator usable at once, no settling.
// RULE_03: Reset pin low disables both oscillators.
// RULE_04: Source select: 0 internal, 1 external, anytime.
// RULE_05: External oscillator may run while unused.
// RULE_06: Missing clock enable arms the clock-loss reset.
// RULE_07: Clock-loss reset fires 100 to 500 us.
// RULE_08: Two unused internal bits read 00b.
// RULE_09: Ready flag shows internal oscillator at speed.
// RULE_10: Internal enable bit turns oscillator on, off.
// RULE_11: Frequency field picks 2, 4, 8, 16 MHz.
// RULE_12: Crystal valid flag reads stable crystal, mode 1xx.
// RULE_13: Software waits 1 ms before reading valid.
// RULE_14: Modes 00x: oscillator off, first pin grounded.
// RULE_15: Mode 010 direct CMOS clock, 011 halved.
// RULE_16: Modes 10x: RC or C oscillator, halved.
// RULE_17: Mode 110 crystal direct, 111 crystal halved.
// RULE_18: Reserved external bit ignores writes.
// RULE_19: Software matches frequency control to the network.
// RULE_20: Clock-loss reset sets its flag, else zero.
// RULE_21: Software switches to crystal after valid rises.
// RULE_22: Source change never makes shortened clock pulses.
package sccs_pkg;
    // Register addresses on the special function register bus.
    localparam logic [7:0] SCCS_ADDR_EXT_CTRL = 8'hB1;
    localparam logic [7:0] SCCS_ADDR_INT_CTRL = 8'hB2;
    // Reset values of the two control registers.
    localparam logic [7:0] SCCS_EXT_CTRL_RST = 8'h30;
    localparam logic [7:0] SCCS_INT_CTRL_RST = 8'h04;
    // Field positions of the internal oscillator control register.
    localparam int SCCS_INT_MCE_BIT = 7;
    localparam int SCCS_INT_RDY_BIT = 4;
    localparam int SCCS_INT_SEL_BIT = 3;
    localparam int SCCS_INT_EN_BIT = 2;
    localparam int SCCS_INT_FREQ_LSB = 0;
    // Field positions of the external oscillator control register.
    localparam int SCCS_EXT_VLD_BIT = 7;
    localparam int SCCS_EXT_MODE_LSB = 4;
    localparam int SCCS_EXT_FREQ_LSB = 0;
    // External oscillator mode codes.
    localparam logic [2:0] SCCS_MODE_OFF = 3'h0;
    localparam logic [2:0] SCCS_MODE_CMOS = 3'h2;
    localparam logic [2:0] SCCS_MODE_CMOS_DIV = 3'h3;
    localparam logic [2:0] SCCS_MODE_XTAL = 3'h6;
    // Timing of the missing clock detector.
    localparam int SCCS_CLK_MHZ = 100;
    localparam int SCCS_MCD_MIN_US = 100;
    localparam int SCCS_MCD_MAX_US = 500;
    localparam int SCCS_MCD_MIN_CYC = SCCS_MCD_MIN_US * SCCS_CLK_MHZ;
    localparam int SCCS_MCD_MAX_CYC = SCCS_MCD_MAX_US * SCCS_CLK_MHZ;
    // States of the glitch-free clock multiplexer.
    typedef enum logic [1:0] {
        SCCS_ST_INT,
        SCCS_ST_EXT,
        SCCS_ST_PARK
    } sccs_mux_state_t;
endpackage : sccs_pkg

// File: core/sccs_sync.sv
`timescale 1ns/100ps
// Two flip-flop synchroniser for asynchronous levels.
module sccs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Levels.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sccs_sync

// File: core/sccs_div2.sv
`timescale 1ns/100ps
// Divide-by-two stage working on a sampled clock level.
module sccs_div2 (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Sampled source level and its halved copy.
    input wire logic clear,
    input wire logic src_lvl,
    output logic half_lvl
);
    logic prev_q;

    // Toggle on each rising edge; clear parks the stage low.
    always_ff @(posedge sys_clk) begin
        if (!rst_b || clear) begin
            prev_q <= 1'b0;
            half_lvl <= 1'b0;
        end else begin
            prev_q <= src_lvl;
            if (src_lvl && !prev_q) begin
                half_lvl <= !half_lvl;
            end
        end
    end
endmodule : sccs_div2

// File: core/sccs_clock_control.sv
`timescale 1ns/100ps
// System clock source control: register file, source selection, divider,
// glitch-free multiplexing and missing clock detection.
module sccs_clock_control
    import sccs_pkg::*;
#(
    parameter int MCD_CYCLES = SCCS_MCD_MIN_CYC,
    parameter int MCD_WIDTH = 16
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Special function register bus.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_q,
    // External reset pin, active low, asynchronous.
    input wire logic rst_pin_b,
    // Oscillator sources and status from the analog circuits.
    input wire logic internal_osc_clk,
    input wire logic internal_osc_locked,
    input wire logic external_osc_clk,
    input wire logic crystal_stable,
    // Controls to the analog circuits.
    output logic internal_osc_on_q,
    output logic [1:0] internal_freq_select_q,
    output logic [2:0] external_osc_mode_q,
    output logic [2:0] external_freq_control_q,
    output logic crystal_pin_one_ground_q,
    // Selected system clock and the reset side.
    output logic system_clock_q,
    output logic missing_clock_reset_q,
    output logic missing_clock_reset_flag_q
);
    // Stored register fields.
    logic missing_clock_enable_q;
    logic clock_source_select_q;
    logic internal_osc_enable_q;
    logic [1:0] internal_freq_select_f_q;
    logic [2:0] external_osc_mode_f_q;
    logic [2:0] external_freq_control_f_q;

    // Synchronised inputs.
    logic pin_ok;
    logic int_clk_s;
    logic int_locked_s;
    logic ext_clk_s;
    logic xtal_stable_s;

    // Derived source levels.
    logic int_lvl;
    logic ext_raw_lvl;
    logic ext_half_lvl;
    logic ext_lvl;
    logic ext_divided;
    logic ext_running;

    // Read-only flags as software sees them.
    logic internal_freq_ready;
    logic crystal_valid_flag;

    // Multiplexer and detector state.
    sccs_mux_state_t mux_q;
    sccs_mux_state_t mux_d;
    logic sysclk_d;
    logic sysclk_prev_q;
    logic [MCD_WIDTH-1:0] mcd_count_q;
    logic rst_seen_q;
    logic wr_int;
    logic wr_ext;

    // Cycle count of the detector timeout, taken from MCD_CYCLES without a check against the legal window.
    localparam logic [MCD_WIDTH-1:0] MCD_LIMIT = MCD_WIDTH'(MCD_CYCLES - 1);

    // Every pin and analog level is brought into the clock domain first.
    sccs_sync #(
        .WIDTH(5)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .async_in({rst_pin_b, internal_osc_clk, internal_osc_locked,
            external_osc_clk, crystal_stable}),
        .sync_out({pin_ok, int_clk_s, int_locked_s, ext_clk_s, xtal_stable_s})
    );

    // Write strobes for the two registers; other addresses are not ours.
    assign wr_int = sfr_wr && (sfr_addr == SCCS_ADDR_INT_CTRL);
    assign wr_ext = sfr_wr && (sfr_addr == SCCS_ADDR_EXT_CTRL);

    // Internal oscillator control register. The ready flag and the two
    // unused bits are not stored, so writes to them have no effect.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            missing_clock_enable_q <= SCCS_INT_CTRL_RST[SCCS_INT_MCE_BIT];
            clock_source_select_q <= SCCS_INT_CTRL_RST[SCCS_INT_SEL_BIT]; // RULE_01
            internal_osc_enable_q <= SCCS_INT_CTRL_RST[SCCS_INT_EN_BIT];
            internal_freq_select_f_q <= SCCS_INT_CTRL_RST[SCCS_INT_FREQ_LSB +: 2];
        end else if (wr_int) begin
            missing_clock_enable_q <= sfr_wdata[SCCS_INT_MCE_BIT]; // RULE_06
            clock_source_select_q <= sfr_wdata[SCCS_INT_SEL_BIT]; // RULE_04
            internal_osc_enable_q <= sfr_wdata[SCCS_INT_EN_BIT]; // RULE_10
            internal_freq_select_f_q <= sfr_wdata[SCCS_INT_FREQ_LSB +: 2]; // RULE_11
        end
    end

    // External oscillator control register. The valid flag and the
    // reserved bit are not stored; the reserved bit drops every write.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            external_osc_mode_f_q <= SCCS_EXT_CTRL_RST[SCCS_EXT_MODE_LSB +: 3];
            external_freq_control_f_q <= SCCS_EXT_CTRL_RST[SCCS_EXT_FREQ_LSB +: 3];
        end else if (wr_ext) begin
            external_osc_mode_f_q <= sfr_wdata[SCCS_EXT_MODE_LSB +: 3];
            external_freq_control_f_q <= sfr_wdata[SCCS_EXT_FREQ_LSB +: 3]; // RULE_18
        end
    end

    // The internal source is live only while enabled and the reset pin is
    // high. No start-up count is applied: the first edge is used at once.
    assign int_lvl = pin_ok && internal_osc_enable_q && int_clk_s; // RULE_02 RULE_03

    // While the reset pin is high the external circuit runs in every mode except 00x,
    // whichever source feeds the system clock, so it can be warmed up before a switch.
    assign ext_running = pin_ok && (external_osc_mode_f_q[2:1] != 2'b00); // RULE_05 RULE_14
    assign ext_raw_lvl = ext_running && ext_clk_s;

    // Mode 010 and 110 pass the source directly; 011, 10x and 111 halve it.
    assign ext_divided = (external_osc_mode_f_q == SCCS_MODE_CMOS_DIV)
        || (external_osc_mode_f_q[2:1] == 2'b10) // RULE_16
        || (external_osc_mode_f_q == (SCCS_MODE_XTAL | 3'h1)); // RULE_17 RULE_15

    // The divider is cleared while the oscillator is off so that a new
    // start always begins with a full low phase.
    sccs_div2 u_div2 (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clear(!ext_running),
        .src_lvl(ext_raw_lvl),
        .half_lvl(ext_half_lvl)
    );

    assign ext_lvl = ext_divided ? ext_half_lvl : ext_raw_lvl; // RULE_15 RULE_17

    // The ready flag needs both the enable and the lock report from the
    // analog part; the lock is lost while the pin holds the part in reset.
    assign internal_freq_ready = pin_ok && internal_osc_enable_q && int_locked_s; // RULE_09

    // The crystal flag is only defined in modes 1xx; elsewhere it reads 0.
    assign crystal_valid_flag = ext_running && external_osc_mode_f_q[2]
        && xtal_stable_s; // RULE_12

    // Glitch-free multiplexer. On a change of select the output waits
    // until the old source is low, holds low until the new source is low
    // too, and only then follows the new source. Neither a high nor a low
    // phase is cut short, at the cost of up to one period of each source.
    always_comb begin
        mux_d = mux_q;
        sysclk_d = 1'b0;
        case (mux_q)
            SCCS_ST_INT: begin
                sysclk_d = int_lvl;
                if (clock_source_select_q && !int_lvl) begin
                    mux_d = SCCS_ST_PARK; // RULE_22
                    sysclk_d = 1'b0;
                end
            end
            SCCS_ST_EXT: begin
                sysclk_d = ext_lvl;
                if (!clock_source_select_q && !ext_lvl) begin
                    mux_d = SCCS_ST_PARK; // RULE_22
                    sysclk_d = 1'b0;
                end
            end
            SCCS_ST_PARK: begin
                if (clock_source_select_q && !ext_lvl) begin
                    mux_d = SCCS_ST_EXT; // RULE_04
                end else if (!clock_source_select_q && !int_lvl) begin
                    mux_d = SCCS_ST_INT; // RULE_04
                end
            end
            default: begin
                mux_d = SCCS_ST_INT;
            end
        endcase
    end

    // Any reset returns the multiplexer to the internal source directly.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mux_q <= SCCS_ST_INT; // RULE_01
            system_clock_q <= 1'b0;
            sysclk_prev_q <= 1'b0;
        end else begin
            mux_q <= mux_d;
            system_clock_q <= sysclk_d;
            sysclk_prev_q <= system_clock_q;
        end
    end

    // Missing clock detector: a one-shot retriggered by each rising edge of
    // the system clock. Once it times out the request stays up until the
    // reset it asks for arrives.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mcd_count_q <= '0;
            missing_clock_reset_q <= 1'b0;
        end else if (!missing_clock_enable_q) begin
            mcd_count_q <= '0; // RULE_06
        end else if (system_clock_q && !sysclk_prev_q) begin
            mcd_count_q <= '0;
        end else if (mcd_count_q == MCD_LIMIT) begin
            missing_clock_reset_q <= 1'b1; // RULE_07
        end else begin
            mcd_count_q <= mcd_count_q + MCD_WIDTH'(1);
        end
    end

    // Reset source flag. It is taken in the first cycle of every reset,
    // so it shows 1 only when this detector caused that reset, and it
    // survives the reset itself so software can read it afterwards.
    // A flag read before the very first reset after power-up is undefined.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rst_seen_q <= 1'b1;
            if (!rst_seen_q) begin
                missing_clock_reset_flag_q <= missing_clock_reset_q; // RULE_20
            end
        end else begin
            rst_seen_q <= 1'b0;
        end
    end

    // Controls to the analog circuits. The pin level forces both
    // oscillators off; the stored fields are not disturbed by it.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            internal_osc_on_q <= 1'b0;
            internal_freq_select_q <= SCCS_INT_CTRL_RST[SCCS_INT_FREQ_LSB +: 2];
            external_osc_mode_q <= SCCS_MODE_OFF;
            external_freq_control_q <= SCCS_EXT_CTRL_RST[SCCS_EXT_FREQ_LSB +: 3];
            crystal_pin_one_ground_q <= 1'b1;
        end else begin
            internal_osc_on_q <= pin_ok && internal_osc_enable_q; // RULE_03 RULE_10
            internal_freq_select_q <= internal_freq_select_f_q; // RULE_11
            external_osc_mode_q <= pin_ok ? external_osc_mode_f_q : SCCS_MODE_OFF; // RULE_03
            external_freq_control_q <= external_freq_control_f_q;
            crystal_pin_one_ground_q <= !ext_running; // RULE_14
        end
    end

    // Read data, registered one cycle after the read strobe. Unused and
    // reserved bits read as zero; other addresses return zero.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata_q <= 8'h00; // RULE_08
            if (sfr_addr == SCCS_ADDR_INT_CTRL) begin
                sfr_rdata_q[SCCS_INT_MCE_BIT] <= missing_clock_enable_q;
                sfr_rdata_q[SCCS_INT_RDY_BIT] <= internal_freq_ready; // RULE_09
                sfr_rdata_q[SCCS_INT_SEL_BIT] <= clock_source_select_q;
                sfr_rdata_q[SCCS_INT_EN_BIT] <= internal_osc_enable_q;
                sfr_rdata_q[SCCS_INT_FREQ_LSB +: 2] <= internal_freq_select_f_q;
            end else if (sfr_addr == SCCS_ADDR_EXT_CTRL) begin
                sfr_rdata_q[SCCS_EXT_VLD_BIT] <= crystal_valid_flag; // RULE_12
                sfr_rdata_q[SCCS_EXT_MODE_LSB +: 3] <= external_osc_mode_f_q;
                sfr_rdata_q[SCCS_EXT_FREQ_LSB +: 3] <= external_freq_control_f_q;
            end
        end
    end
endmodule : sccs_clock_control

// File: bench/sccs_chk.sv
`timescale 1ns/100ps
// Port-level checker for the clock source control block.
module sccs_chk
    import sccs_pkg::*;
#(
    parameter int MCD_CYCLES = 20,
    parameter int MCD_WIDTH = 16
) (
    // Clock, reset and register bus.
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata_q,
    // Pin, sources and outputs.
    input wire logic rst_pin_b,
    input wire logic internal_osc_clk,
    input wire logic internal_osc_locked,
    input wire logic external_osc_clk,
    input wire logic crystal_stable,
    input wire logic internal_osc_on_q,
    input wire logic [1:0] internal_freq_select_q,
    input wire logic [2:0] external_osc_mode_q,
    input wire logic [2:0] external_freq_control_q,
    input wire logic crystal_pin_one_ground_q,
    input wire logic system_clock_q,
    input wire logic missing_clock_reset_q,
    input wire logic missing_clock_reset_flag_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    logic mce_q, sc_d, cap_q;
    logic rst_d = 1'b0;
    logic seen_q = 1'b0;
    logic [31:0] idle_q;
    logic [3:0] lock_lo_q = 4'h0;
    logic [3:0] stab_lo_q = 4'h0;
    logic [3:0] src_lo_q = 4'h0;
    // Shadow of the detector enable, kept from the writes seen on the bus.
    always_ff @(posedge sys_clk) begin
        if (!rst_b)
            mce_q <= 1'b0;
        else if (sfr_wr && sfr_addr == SCCS_ADDR_INT_CTRL)
            mce_q <= sfr_wdata[7];
    end
    // Idle time since the last clock rise; cleared while the detector is off.
    always_ff @(posedge sys_clk) begin
        sc_d <= system_clock_q;
        if (!rst_b || !mce_q || (system_clock_q && !sc_d))
            idle_q <= 32'h0;
        else if (idle_q < 32'hFFFF)
            idle_q <= idle_q + 32'h1;
    end
    // Saturating low-time counters give the synchronisers time to settle.
    always_ff @(posedge sys_clk) begin
        lock_lo_q <= internal_osc_locked ? 4'h0 : lock_lo_q + {3'h0, lock_lo_q != 4'hF};
        stab_lo_q <= crystal_stable ? 4'h0 : stab_lo_q + {3'h0, stab_lo_q != 4'hF};
        src_lo_q <= (internal_osc_clk || external_osc_clk) ? 4'h0 :
            src_lo_q + {3'h0, src_lo_q != 4'hF};
    end
    // Request level at the first edge of each reset; the power-up reset is skipped.
    always_ff @(posedge sys_clk) begin
        rst_d <= rst_b;
        if (!rst_b && rst_d)
            cap_q <= missing_clock_reset_q;
        if (rst_b && !rst_d)
            seen_q <= 1'b1;
    end

    property p_boot;
        $rose(rst_b) |-> !system_clock_q && !missing_clock_reset_q && internal_freq_select_q == 2'h0;
    endproperty
    a_boot: assert property (p_boot) else $error("outputs not at reset state");
    property p_pin_off;
        !rst_pin_b [*4] |-> !internal_osc_on_q && external_osc_mode_q == SCCS_MODE_OFF;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("oscillator on with pin low");
    property p_ground;
        crystal_pin_one_ground_q == (external_osc_mode_q[2:1] == 2'h0);
    endproperty
    a_ground: assert property (p_ground) else $error("pin ground disagrees with mode");
    property p_unused;
        sfr_rd && sfr_addr == SCCS_ADDR_INT_CTRL |=> sfr_rdata_q[6:5] == 2'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits read nonzero");
    property p_ready;
        sfr_rd && sfr_addr == SCCS_ADDR_INT_CTRL && lock_lo_q > 4'h5 |=> !sfr_rdata_q[4];
    endproperty
    a_ready: assert property (p_ready) else $error("ready set while unlocked");
    property p_xvalid;
        sfr_rd && sfr_addr == SCCS_ADDR_EXT_CTRL && stab_lo_q > 4'h5 |=> !sfr_rdata_q[7];
    endproperty
    a_xvalid: assert property (p_xvalid) else $error("crystal valid while unstable");
    // The field is stored at the write edge and reaches the output one edge later.
    property p_freq;
        sfr_wr && sfr_addr == SCCS_ADDR_INT_CTRL |-> ##2
            internal_freq_select_q == $past(sfr_wdata[1:0], 2);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency field not taken");
    property p_mcd;
        $rose(missing_clock_reset_q) |-> mce_q && idle_q >= MCD_CYCLES - 2;
    endproperty
    a_mcd: assert property (p_mcd) else $error("clock loss reset early");
    property p_glitch;
        $rose(system_clock_q) |-> src_lo_q < 4'h7;
    endproperty
    a_glitch: assert property (p_glitch) else $error("clock rise without source");
    property p_flag;
        rst_b && !rst_d && seen_q |-> missing_clock_reset_flag_q == cap_q;
    endproperty
    a_flag: assert property (p_flag) else $error("reset cause flag wrong");
    c_mcd: cover property ($rose(missing_clock_reset_q));
    c_div: cover property (system_clock_q && external_osc_mode_q == SCCS_MODE_CMOS_DIV);
    c_pin: cover property (!rst_pin_b [*4]);
endmodule : sccs_chk

bind sccs_clock_control sccs_chk #(.MCD_CYCLES(MCD_CYCLES), .MCD_WIDTH(MCD_WIDTH)) sccs_chk_i (.*);

// File: bench/sccs_tb.sv
`timescale 1ns/100ps
// Self-checking bench; sources are toggled behaviourally at the falling edge.
module tb;
    import sccs_pkg::*;
    localparam int MCD = 20;
    logic sys_clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, rst_pin_b = 1;
    logic internal_osc_clk = 0, external_osc_clk = 0;
    logic internal_osc_locked = 1, crystal_stable = 0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_q, d;
    logic internal_osc_on_q, crystal_pin_one_ground_q, system_clock_q;
    logic missing_clock_reset_q, missing_clock_reset_flag_q;
    logic [1:0] internal_freq_select_q;
    logic [2:0] external_osc_mode_q, external_freq_control_q;
    int error_cnt = 0, num_checks = 0, ic = 0, ec = 0, r, n;
    bit int_run = 1, ext_run = 1;

    sccs_clock_control #(.MCD_CYCLES(MCD)) sccs_clock_control_i (.*);

    always #5 sys_clk = ~sys_clk;
    // Internal source has a period of 4 cycles, external of 6; stopped ones sit low.
    always @(negedge sys_clk) begin
        ic = ic + 1;
        ec = ec + 1;
        if (!int_run) internal_osc_clk <= 1'b0;
        else if (ic >= 2) begin
            ic = 0;
            internal_osc_clk <= ~internal_osc_clk;
        end
        if (!ext_run) external_osc_clk <= 1'b0;
        else if (ec >= 3) begin
            ec = 0;
            external_osc_clk <= ~external_osc_clk;
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1;
        @(negedge sys_clk);
        sfr_wr = 0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1;
        @(negedge sys_clk);
        sfr_rd = 0;
        d = sfr_rdata_q;
    endtask : rd
    // Counts rising edges of the system clock over k cycles.
    task automatic rises(input int k);
        logic p;
        r = 0;
        p = system_clock_q;
        repeat (k) begin
            @(negedge sys_clk);
            if (system_clock_q === 1'b1 && p === 1'b0) r++;
            p = system_clock_q;
        end
    endtask : rises

    // Reset values, masked bits, unmapped address and the crystal flag.
    task automatic t_regs;
        // The pin and lock levels need two synchroniser edges after reset.
        idle(3);
        rd(SCCS_ADDR_INT_CTRL); chk(d, 8'h14);
        rd(SCCS_ADDR_EXT_CTRL); chk(d, SCCS_EXT_CTRL_RST);
        wr(8'hB3, 8'hFF); rd(8'hB3); chk(d, 8'h00);
        wr(SCCS_ADDR_INT_CTRL, 8'h77); rd(SCCS_ADDR_INT_CTRL); chk(d, 8'h17);
        wr(SCCS_ADDR_EXT_CTRL, 8'hFF); idle(6);
        rd(SCCS_ADDR_EXT_CTRL); chk(d, 8'h77);
        // Settling wait before polling the flag, scaled down to keep the run short.
        crystal_stable = 1; idle(6);
        rd(SCCS_ADDR_EXT_CTRL); chk(d, 8'hF7);
        // Only once the flag is up is the halved crystal taken: period 12 cycles.
        wr(SCCS_ADDR_INT_CTRL, 8'h0C); idle(20); rises(60);
        chk({7'h0, r >= 4 && r <= 6}, 8'h01);
        wr(SCCS_ADDR_INT_CTRL, 8'h04); idle(20);
        crystal_stable = 0;
    endtask : t_regs
    // Every mode and frequency code, then the enable bit and ready flag.
    task automatic t_modes;
        for (int m = 0; m < 8; m++) begin
            wr(SCCS_ADDR_EXT_CTRL, {1'b0, 3'(m), 4'h5}); idle(4);
            chk({5'h0, external_osc_mode_q}, 8'(m));
            chk({7'h0, crystal_pin_one_ground_q}, {7'h0, m < 2});
            chk({5'h0, external_freq_control_q}, 8'h05);
        end
        for (int f = 0; f < 4; f++) begin
            wr(SCCS_ADDR_INT_CTRL, {6'h01, 2'(f)}); idle(4);
            chk({6'h0, internal_freq_select_q}, 8'(f));
            chk({7'h0, internal_osc_on_q}, 8'h01);
        end
        wr(SCCS_ADDR_INT_CTRL, 8'h00); internal_osc_locked = 0; idle(8);
        chk({7'h0, internal_osc_on_q}, 8'h00);
        rd(SCCS_ADDR_INT_CTRL); chk(d, 8'h00);
        internal_osc_locked = 1;
        wr(SCCS_ADDR_INT_CTRL, 8'h04); rises(12);
        chk({7'h0, r >= 2}, 8'h01);
    endtask : t_modes
    // Switching between sources, direct and halved external clock.
    task automatic t_switch;
        wr(SCCS_ADDR_EXT_CTRL, 8'h20); wr(SCCS_ADDR_INT_CTRL, 8'h0C);
        int_run = 0; idle(10); rises(60);
        chk({7'h0, r >= 9 && r <= 11}, 8'h01);
        wr(SCCS_ADDR_EXT_CTRL, 8'h30); idle(10); rises(60);
        chk({7'h0, r >= 4 && r <= 6}, 8'h01);
        int_run = 1; wr(SCCS_ADDR_INT_CTRL, 8'h04); idle(10); rises(60);
        chk({7'h0, r >= 13 && r <= 16}, 8'h01);
        chk({5'h0, external_osc_mode_q}, 8'h03);
    endtask : t_switch
    // Reset pin low stops both oscillators; fields survive.
    task automatic t_pin;
        rst_pin_b = 0; idle(6);
        chk({6'h0, internal_osc_on_q, crystal_pin_one_ground_q}, 8'h01);
        chk({5'h0, external_osc_mode_q}, 8'h00);
        rises(20); chk(8'(r), 8'h00);
        rst_pin_b = 1; idle(6);
        chk({5'h0, external_osc_mode_q}, 8'h03);
    endtask : t_pin
    // Detector off, then armed with both sources stopped, then two resets.
    task automatic t_mcd;
        ext_run = 0; int_run = 0;
        wr(SCCS_ADDR_INT_CTRL, 8'h0C); idle(3 * MCD);
        chk({7'h0, missing_clock_reset_q}, 8'h00);
        wr(SCCS_ADDR_INT_CTRL, 8'h8C);
        n = 0;
        while (missing_clock_reset_q !== 1'b1 && n < 3 * MCD) begin
            idle(1); n++;
        end
        chk({7'h0, n >= MCD - 4 && n <= MCD + 4}, 8'h01);
        rst_b = 0; idle(2); rst_b = 1; int_run = 1; ext_run = 1;
        chk({6'h0, missing_clock_reset_flag_q, missing_clock_reset_q}, 8'h02);
        idle(2);
        rd(SCCS_ADDR_INT_CTRL); chk(d, 8'h14);
        rises(20); chk({7'h0, r >= 4}, 8'h01);
        rst_b = 0; idle(2); rst_b = 1;
        chk({7'h0, missing_clock_reset_flag_q}, 8'h00);
    endtask : t_mcd

    task automatic finish_test;
        $display("Errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // Main sequence after a two-cycle reset.
    initial begin
        idle(2); rst_b = 1;
        t_regs; t_modes; t_switch; t_pin; t_mcd;
        finish_test;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #200000;
        error_cnt++;
        $display("Error %0t: timeout", $time);
        finish_test;
    end
endmodule : tb
